// ==== design/tlem_defines.vh ====
// constants of the two-level event manager: register
// indices, field positions, masks and reset values.
// assumes a 32-bit bus; register index = byte address / 4.
`ifndef TLEM_DEFINES_VH
`define TLEM_DEFINES_VH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define TLEM_IDX_FLAG    16'h4600
`define TLEM_IDX_SWCTRL  16'h460A
`define TLEM_IDX_MISS    16'h4610
`define TLEM_IDX_GATE    16'h4618
`define TLEM_IDX_CFG     16'h461A
`define TLEM_IDX_FLAG2   16'h4620
`define TLEM_IDX_CFG2    16'h4624
`define TLEM_IDX_STAT    16'h4630
`define TLEM_IDX_SMASK   16'h4631

// ****************************************
// top-level bit positions
// ****************************************
`define TLEM_BIT_SW      1
`define TLEM_BIT_SC1     5
`define TLEM_BIT_SC2     6
`define TLEM_BIT_GPIO    12
`define TLEM_BIT_TMR     13
`define TLEM_BIT_GATE    0

// ****************************************
// masks and reset values
// ****************************************
`define TLEM_RST16       16'h0000
`define TLEM_RST2        2'h0
`define TLEM_ONES16      16'hFFFF
`define TLEM_TOP_VALID   16'hFFFE
`define TLEM_DIRECT      16'hCF9E
`define TLEM_APP_MASK    16'h3860
`define TLEM_SW_MASK     16'h0002
`define TLEM_IDX_LO      2
`define TLEM_IDX_HI      17
`define TLEM_HTRANS_ACT  1
`define TLEM_HPROT_PRIV  1
`define TLEM_ST_MISS     0
`define TLEM_ST_BLOCK    1

`endif

// ==== design/tlem_event_manager.v ====
// two-level event manager: pending, enable and missed-event
// registers behind an ahb-lite slave, a cpu irq, a status irq and one wake line.
// assumes event pulses come from logic on hclk (no synchroniser)
// and that hprot[1] low marks an application-mode access.
//
// Overview of operation
// - cpu irq, status irq and one wake line out
// - event pulse sets its pending bit
// - top and second level flag/enable registers
// - direct modules have only top bits
// - top enable gates top pending bit
// - sub events need both enables set
// - write one clears only that bit
// - module top bit is OR of enabled subs
// - set wins over same-cycle clear
// - repeated events merge, never counted
// - enabled recurrence while pending sets missed bit
// - pending survives global disable, reasserts later
// - application top flag/enable/miss writes limited to app bits
// - soft trigger write raises software event
// - global gate bit zero, others read zero
// - application cannot touch system enable bits
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/10ps
`include "tlem_defines.vh"

module tlem_event_manager
(
   input  wire        hclk,      // bus clock, 100 MHz
   input  wire        hresetn,   // async reset, active low
   input  wire        hsel,      // slave select
   input  wire [31:0] haddr,     // byte address
   input  wire [1:0]  htrans,    // transfer type
   input  wire        hwrite,    // write when high
   input  wire [2:0]  hsize,     // transfer size, word only
   input  wire [3:0]  hprot,     // protection, bit 1 privileged
   input  wire [31:0] hwdata,    // write data
   input  wire        hready,    // bus ready in
   output reg  [31:0] hrdata,    // read data
   output reg         hreadyout, // slave ready
   output reg         hresp,     // always okay
   input  wire [15:0] top_evt,   // direct top-level event pulses
   input  wire [15:0] tmr_evt,   // timer sub-event pulses
   input  wire [15:0] gpio_evt,  // gpio sub-events
   input  wire [15:0] sc1_evt,   // serial 1 sub-event pulses
   input  wire [15:0] sc2_evt,   // serial 2 sub-event pulses
   output reg         cpu_irq,   // processor interrupt request
   output reg         cpu_wake,  // processor wake-up
   output reg         err_irq    // manager status interrupt
);

   // ****************************************
   // functions
   // ****************************************

   // write mask for top-level registers per access mode
   function [15:0] wmask;
      input priv;
      begin
         // system bits are shielded from applications
         wmask = priv ? `TLEM_ONES16 : `TLEM_APP_MASK;
      end
   endfunction

   // bits that a write-one clears on a given register
   function [15:0] w1c;
      input        hit;
      input [15:0] data;
      input [15:0] mask;
      begin
         w1c = hit ? (data & mask) : `TLEM_RST16;
      end
   endfunction

   // ****************************************
   // bus address and data phase
   // ****************************************
   reg  [15:0] d_idx;       // index latched in address phase
   reg         d_wr;        // a write is in its data phase
   reg         d_priv;      // privileged access flag
   wire [15:0] a_idx;       // index of current address phase
   wire        take;        // address phase accepted
   wire [15:0] wdat;        // low half of write data

   assign a_idx = haddr[`TLEM_IDX_HI:`TLEM_IDX_LO];
   assign take  = hsel & hready & htrans[`TLEM_HTRANS_ACT];
   assign wdat  = hwdata[15:0];

   // latch the address phase; zero wait states always
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         d_idx     <= `TLEM_RST16;
         d_wr      <= 1'b0;
         d_priv    <= 1'b0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         // only okay responses on this slave
         hresp     <= 1'b0;
         d_wr      <= take & hwrite;
         if (take)
         begin
            d_idx  <= a_idx;
            d_priv <= hprot[`TLEM_HPROT_PRIV];
         end
      end
   end

   // ****************************************
   // register state
   // ****************************************
   reg  [15:0] flag;        // top pending, direct sources only
   reg  [15:0] cfg;         // top enable mask
   reg  [15:0] miss;        // top missed-event register
   reg         gate;        // global irq gate
   reg  [15:0] flag2 [0:3]; // second-level pending
   reg  [15:0] cfg2  [0:3]; // second-level enable
   reg  [1:0]  stat;        // sticky manager status
   reg  [1:0]  smask;       // status mask

   // ****************************************
   // event combination
   // ****************************************
   wire [15:0] sub_evt [0:3]; // sub events per peripheral
   wire [3:0]  sub_on;        // any enabled sub pending
   wire [3:0]  sub_mis;       // any enabled sub recurred
   wire [15:0] sw_vec;        // software event vector
   wire [15:0] evt_top;       // all direct top events
   wire [15:0] sub_top;       // sub summaries at top bits
   wire [15:0] sub_mtop;      // sub misses at top bits
   wire [15:0] top_view;      // visible top pending
   wire [15:0] miss_ev;       // missed events this cycle
   wire        sw_hit;        // soft trigger written

   assign sub_evt[0] = tmr_evt;
   assign sub_evt[1] = gpio_evt;
   assign sub_evt[2] = sc1_evt;
   assign sub_evt[3] = sc2_evt;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_sub
         assign sub_on[g]  = |(flag2[g] & cfg2[g]);
         assign sub_mis[g] = |(sub_evt[g] & flag2[g] & cfg2[g]);
      end
   endgenerate

   // place second-level summaries on module bits
   assign sub_top = (sub_on[0] ? (16'h0001 << `TLEM_BIT_TMR) : `TLEM_RST16)
                  | (sub_on[1] ? (16'h0001 << `TLEM_BIT_GPIO) : `TLEM_RST16)
                  | (sub_on[2] ? (16'h0001 << `TLEM_BIT_SC1) : `TLEM_RST16)
                  | (sub_on[3] ? (16'h0001 << `TLEM_BIT_SC2) : `TLEM_RST16);
   assign sub_mtop = (sub_mis[0] ? (16'h0001 << `TLEM_BIT_TMR) : `TLEM_RST16)
                   | (sub_mis[1] ? (16'h0001 << `TLEM_BIT_GPIO) : `TLEM_RST16)
                   | (sub_mis[2] ? (16'h0001 << `TLEM_BIT_SC1) : `TLEM_RST16)
                   | (sub_mis[3] ? (16'h0001 << `TLEM_BIT_SC2) : `TLEM_RST16);

   // soft trigger write is a software event
   assign sw_hit  = d_wr & (d_idx == `TLEM_IDX_SWCTRL);
   assign sw_vec  = sw_hit ? `TLEM_SW_MASK : `TLEM_RST16;
   // direct modules use top bits only
   assign evt_top = (top_evt | sw_vec) & `TLEM_DIRECT;
   assign top_view = (flag & `TLEM_DIRECT) | sub_top;
   // missed on enabled recurrence, either level
   assign miss_ev = (evt_top & flag & cfg) | sub_mtop;

   // ****************************************
   // write decode
   // ****************************************
   wire        hit_flag;    // write to top pending
   wire        hit_cfg;     // write to top enable
   wire        hit_miss;    // write to missed register
   wire        hit_gate;    // write to global gate
   wire        hit_stat;    // write to status
   wire        hit_smask;   // write to status mask
   wire [15:0] tmask;       // mode-dependent top mask
   wire        blocked;     // application hit a system bit
   wire        rd_stat;     // read of status, clears it

   assign hit_flag  = d_wr & (d_idx == `TLEM_IDX_FLAG);
   assign hit_cfg   = d_wr & (d_idx == `TLEM_IDX_CFG);
   assign hit_miss  = d_wr & (d_idx == `TLEM_IDX_MISS);
   assign hit_gate  = d_wr & (d_idx == `TLEM_IDX_GATE);
   assign hit_stat  = d_wr & (d_idx == `TLEM_IDX_STAT);
   assign hit_smask = d_wr & (d_idx == `TLEM_IDX_SMASK);
   assign tmask     = wmask(d_priv);
   assign blocked   = (hit_flag | hit_cfg | hit_miss)
                    & (|(wdat & ~tmask & `TLEM_TOP_VALID));
   assign rd_stat   = take & ~hwrite & (a_idx == `TLEM_IDX_STAT);

   // ****************************************
   // top-level registers
   // ****************************************
   // pending, enable, missed and global gate
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         flag <= `TLEM_RST16;
         cfg  <= `TLEM_RST16;
         miss <= `TLEM_RST16;
         gate <= 1'b0;
      end
      else
      begin
         // pulse sets pending; set beats clear
         flag <= ((flag & ~w1c(hit_flag, wdat, tmask)) | evt_top)
               & `TLEM_DIRECT;
         // missed bit, write one clears, set wins
         miss <= ((miss & ~w1c(hit_miss, wdat, tmask)) | miss_ev)
               & `TLEM_TOP_VALID;
         // system enable bits locked for applications
         if (hit_cfg)
         begin
            cfg <= ((cfg & ~tmask) | (wdat & tmask)) & `TLEM_TOP_VALID;
         end
         if (hit_gate)
         begin
            gate <= wdat[`TLEM_BIT_GATE];
         end
      end
   end

   // ****************************************
   // second-level registers
   // ****************************************
   // applications have full access here
   integer k;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (k = 0; k < 4; k = k + 1)
         begin
            flag2[k] <= `TLEM_RST16;
            cfg2[k]  <= `TLEM_RST16;
         end
      end
      else
      begin
         for (k = 0; k < 4; k = k + 1)
         begin
            // write one clears; set beats clear
            flag2[k] <= (flag2[k]
                       & ~w1c(d_wr & (d_idx == `TLEM_IDX_FLAG2 + k[15:0]),
                              wdat, `TLEM_ONES16)) | sub_evt[k];
            if (d_wr & (d_idx == `TLEM_IDX_CFG2 + k[15:0]))
            begin
               cfg2[k] <= wdat;
            end
         end
      end
   end

   // ****************************************
   // manager status and its interrupt
   // ****************************************
   // sticky status, read clears, set wins over clear
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         stat  <= `TLEM_RST2;
         smask <= `TLEM_RST2;
      end
      else
      begin
         stat[`TLEM_ST_MISS]  <= (stat[`TLEM_ST_MISS] & ~rd_stat)
                               | (|miss_ev);
         stat[`TLEM_ST_BLOCK] <= (stat[`TLEM_ST_BLOCK] & ~rd_stat)
                               | blocked;
         if (hit_smask)
         begin
            smask <= wdat[1:0];
         end
      end
   end

   // ****************************************
   // processor lines
   // ****************************************
   // registered outputs; irq follows one cycle after state
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cpu_irq  <= 1'b0;
         cpu_wake <= 1'b0;
         err_irq  <= 1'b0;
      end
      else
      begin
         // all sources merged onto one line
         // pending kept, irq returns when gated on
         cpu_irq  <= gate & (|(top_view & cfg));
         // wake ignores the gate so sleep can end
         cpu_wake <= |(top_view & cfg);
         err_irq  <= |(stat & smask);
      end
   end

   // ****************************************
   // read data
   // ****************************************
   reg [15:0] rd_val;       // selected register value

   // decode in the address phase, present in the data phase
   always @*
   begin
      rd_val = `TLEM_RST16;
      case (a_idx)
         `TLEM_IDX_FLAG:
            rd_val = top_view;
         `TLEM_IDX_CFG:
            rd_val = cfg;
         `TLEM_IDX_MISS:
            rd_val = miss;
         `TLEM_IDX_GATE:
            rd_val = {15'h0000, gate};
         `TLEM_IDX_FLAG2:
            rd_val = flag2[0];
         `TLEM_IDX_FLAG2 + 16'h0001:
            rd_val = flag2[1];
         `TLEM_IDX_FLAG2 + 16'h0002:
            rd_val = flag2[2];
         `TLEM_IDX_FLAG2 + 16'h0003:
            rd_val = flag2[3];
         `TLEM_IDX_CFG2:
            rd_val = cfg2[0];
         `TLEM_IDX_CFG2 + 16'h0001:
            rd_val = cfg2[1];
         `TLEM_IDX_CFG2 + 16'h0002:
            rd_val = cfg2[2];
         `TLEM_IDX_CFG2 + 16'h0003:
            rd_val = cfg2[3];
         `TLEM_IDX_STAT:
            rd_val = {14'h0000, stat};
         `TLEM_IDX_SMASK:
            rd_val = {14'h0000, smask};
         // unmapped and soft trigger read zero
         default:
            rd_val = `TLEM_RST16;
      endcase
   end

   // capture read data; same-cycle writes show next read
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= {`TLEM_RST16, `TLEM_RST16};
      end
      else if (take & ~hwrite)
      begin
         hrdata <= {`TLEM_RST16, rd_val};
      end
   end

endmodule // tlem_event_manager

// ==== tb/tlem_monitor.sv ====
// checker: bus and irq relations of the event manager.
// assumes it is bound to tlem_event_manager, sees ports only.
`timescale 1ns/10ps

module tlem_monitor
(
   input wire        hclk,      // clock
   input wire        hresetn,   // reset, low
   input wire        hsel,      // select
   input wire [1:0]  htrans,    // transfer type
   input wire        hwrite,    // write
   input wire        hready,    // ready in
   input wire [31:0] hrdata,    // read data
   input wire        hreadyout, // ready out
   input wire        hresp,     // response
   input wire [15:0] top_evt,   // direct events
   input wire [15:0] tmr_evt,   // timer events
   input wire [15:0] gpio_evt,  // gpio events
   input wire [15:0] sc1_evt,   // serial 1 events
   input wire [15:0] sc2_evt,   // serial 2 events
   input wire        cpu_irq,   // irq out
   input wire        cpu_wake,  // wake out
   input wire        err_irq    // status irq
);
   // ****************************************
   // cause history
   // ****************************************
   wire       take = hsel & hready & htrans[1];                    // address taken
   wire       evt_any = |{top_evt, tmr_evt, gpio_evt, sc1_evt, sc2_evt}; // any pulse
   reg        wr_dp;                                               // write data phase
   reg  [2:0] hist;                                                // recent causes
   // three-deep window tolerates one cycle of extra latency
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_dp <= 1'b0;
         hist  <= 3'h0;
      end
      else
      begin
         wr_dp <= take & hwrite;
         hist  <= {hist[1:0], wr_dp | take | evt_any};
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ****************************************
   // assertions
   // ****************************************
   irq_needs_wake_a: assert property (cpu_irq |-> cpu_wake)
      else $error("irq high while wake low");
   wake_rise_cause_a: assert property ($rose(cpu_wake) |-> |hist)
      else $error("wake rose with no event or write");
   wake_fall_cause_a: assert property ($fell(cpu_wake) |-> hist[1] || hist[2])
      else $error("wake fell with no write");
   irq_fall_cause_a: assert property ($fell(cpu_irq) |-> |hist)
      else $error("irq fell with no write");
   err_rise_cause_a: assert property ($rose(err_irq) |-> |hist)
      else $error("status irq rose with no cause");
   ready_always_a: assert property (hreadyout)
      else $error("wait state inserted");
   resp_okay_a: assert property (!hresp)
      else $error("error response seen");
   rdata_hold_a: assert property (!$past(take && !hwrite) |-> $stable(hrdata))
      else $error("read data moved without read");
   irq_seen_c: cover property ($rose(cpu_irq));
   err_seen_c: cover property ($rose(err_irq));
   wake_only_c: cover property (cpu_wake && !cpu_irq);
endmodule // tlem_monitor

// ==== tb/tlem_core_model.sv ====
// processor core side: watches the irq and wake lines.
// assumes both lines are levels on hclk.
`timescale 1ns/10ps

module tlem_core_model
(
   input wire       hclk,     // core clock
   input wire       hresetn,  // reset, low
   input wire       cpu_irq,  // irq line
   input wire       cpu_wake, // wake line
   output reg [7:0] irq_seen  // irq entries taken
);
   reg irq_q; // last irq level
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_q    <= 1'b0;
         irq_seen <= 8'h00;
      end
      else
      begin
         irq_q <= cpu_irq;
         if (cpu_irq && !irq_q && cpu_wake)
            irq_seen <= irq_seen + 8'h01; // entry on rising level
      end
   end
endmodule // tlem_core_model

// ==== tb/tlem_testbench.sv ====
// self-checking bench for the two-level event manager.
// assumes the design folder is on the include path.
`timescale 1ns/10ps
`include "tlem_defines.vh"
`define CHK(nm, e, g) begin compares = compares + 1; if ((g) !== (e)) begin \
   bad_count = bad_count + 1; $display("ERROR %s expected %h seen %h", nm, e, g); end end

module testbench;
   reg         hclk;      // clock
   reg         hresetn;   // reset, low
   reg         hsel;      // select
   reg  [31:0] haddr;     // address
   reg  [1:0]  htrans;    // transfer type
   reg         hwrite;    // write
   reg  [3:0]  hprot;     // privilege bit 1
   reg  [31:0] hwdata;    // write data
   reg  [15:0] evt [0:4]; // top, tmr, gpio, sc1, sc2
   reg  [15:0] dp_evt;    // top events in data phase
   reg  [31:0] rd;        // last read data
   wire [31:0] hrdata;    // read data
   wire        hreadyout; // ready
   wire        hresp;     // response
   wire        cpu_irq;   // irq
   wire        cpu_wake;  // wake
   wire        err_irq;   // status irq
   wire [7:0]  irq_seen;  // core entries
   integer     bad_count; // mismatches
   integer     compares;  // comparisons
   localparam [15:0] i_flg = `TLEM_IDX_FLAG;
   localparam [15:0] i_cfg = `TLEM_IDX_CFG;
   localparam [15:0] i_sc1f = `TLEM_IDX_FLAG2 + 16'h0002;
   localparam [15:0] i_sc1c = `TLEM_IDX_CFG2 + 16'h0002;

   always #5 hclk = ~hclk;

   tlem_event_manager dut
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hprot(hprot), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .top_evt(evt[0]), .tmr_evt(evt[1]),
      .gpio_evt(evt[2]), .sc1_evt(evt[3]), .sc2_evt(evt[4]), .cpu_irq(cpu_irq),
      .cpu_wake(cpu_wake), .err_irq(err_irq)
   );
   tlem_core_model core
   (
      .hclk(hclk), .hresetn(hresetn), .cpu_irq(cpu_irq), .cpu_wake(cpu_wake), .irq_seen(irq_seen)
   );

   // ****************************************
   // bus tasks
   // ****************************************
   task finish_test;
      begin
         $display("compares %0d mismatches %0d", compares, bad_count);
         if (bad_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // bounded wait for ready at a rising edge
   task wait_rdy;
      integer n;
      begin
         n = 0;
         @(posedge hclk);
         while (hreadyout !== 1'b1)
         begin
            n = n + 1;
            if (n > 20)
            begin
               bad_count = bad_count + 1;
               finish_test;
            end
            @(posedge hclk);
         end
      end
   endtask
   // one single transfer; app low means privileged
   task bus(input [15:0] idx, input w, input [15:0] d, input app);
      begin
         hsel   <= 1'b1;
         haddr  <= {14'h0000, idx, 2'b00};
         htrans <= 2'b10;
         hwrite <= w;
         hprot  <= {2'b00, ~app, 1'b1};
         wait_rdy;
         hsel   <= 1'b0;
         htrans <= 2'b00;
         hwdata <= {16'h0000, d};
         // touch the direct events only when a data-phase event is wanted
         if (dp_evt != 16'h0000)
            evt[0] <= dp_evt;
         wait_rdy;
         if (dp_evt != 16'h0000)
            evt[0] <= 16'h0000;
         rd = hrdata;
      end
   endtask
   task rdc(input [15:0] idx, input [15:0] e);
      begin
         bus(idx, 1'b0, 16'h0000, 1'b0);
         `CHK($sformatf("reg %h", idx), {16'h0000, e}, rd)
      end
   endtask
   task pulse(input integer k, input [15:0] b);
      begin
         evt[k] <= b;
         @(posedge hclk);
         evt[k] <= 16'h0000;
      end
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00;
      hwrite = 1'b0; hprot = 4'h3; hwdata = 32'h0000_0000; dp_evt = 16'h0000;
      evt[0] = 16'h0000; evt[1] = 16'h0000; evt[2] = 16'h0000; evt[3] = 16'h0000; evt[4] = 16'h0000;
      bad_count = 0;
      compares = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc(`TLEM_IDX_GATE, 16'h0000);
      rdc(i_cfg, 16'h0000);
      rdc(`TLEM_IDX_MISS, 16'h0000);
      bus(`TLEM_IDX_STAT, 1'b0, 16'h0000, 1'b0);
      $display("test reset values done");
      begin : wr_direct
         bus(i_cfg, 1'b1, 16'h0800, 1'b0);
         pulse(0, 16'h0800);
         repeat (3) @(posedge hclk);
         `CHK("cpu_irq", 1'b0, cpu_irq)
         `CHK("cpu_wake", 1'b1, cpu_wake)
         rdc(i_flg, 16'h0800);
         bus(`TLEM_IDX_GATE, 1'b1, 16'hFFFF, 1'b0);
         rdc(`TLEM_IDX_GATE, 16'h0001);
         `CHK("cpu_irq", 1'b1, cpu_irq)
         // the core model counts on the edge after irq rises
         @(posedge hclk);
         `CHK("irq_seen", 8'h01, irq_seen)
         pulse(0, 16'h0800);
         repeat (2) @(posedge hclk);
         rdc(`TLEM_IDX_MISS, 16'h0800);
         rdc(i_flg, 16'h0800);
         bus(`TLEM_IDX_MISS, 1'b1, 16'h0800, 1'b0);
         rdc(`TLEM_IDX_MISS, 16'h0000);
         bus(i_flg, 1'b1, 16'h0000, 1'b0);
         rdc(i_flg, 16'h0800);
         dp_evt = 16'h0800;
         bus(i_flg, 1'b1, 16'h0800, 1'b0);
         dp_evt = 16'h0000;
         rdc(i_flg, 16'h0800);
         bus(i_flg, 1'b1, 16'h0800, 1'b0);
         rdc(i_flg, 16'h0000);
         `CHK("cpu_irq", 1'b0, cpu_irq)
      end
      $display("test direct events done");
      bus(i_sc1c, 1'b1, 16'h0003, 1'b0);
      pulse(3, 16'h0001);
      repeat (2) @(posedge hclk);
      `CHK("cpu_wake", 1'b0, cpu_wake)
      rdc(i_flg, 16'h0020);
      bus(i_cfg, 1'b1, 16'h0820, 1'b0);
      repeat (2) @(posedge hclk);
      `CHK("cpu_irq", 1'b1, cpu_irq)
      pulse(3, 16'h0002);
      repeat (2) @(posedge hclk);
      rdc(i_sc1f, 16'h0003);
      // enabled sub event again while pending: serial 1 missed bit
      pulse(3, 16'h0002);
      rdc(`TLEM_IDX_MISS, 16'h0820);
      bus(i_sc1f, 1'b1, 16'h0001, 1'b0);
      rdc(i_flg, 16'h0020);
      bus(i_sc1f, 1'b1, 16'h0002, 1'b0);
      rdc(i_flg, 16'h0000);
      pulse(3, 16'h0004);
      repeat (2) @(posedge hclk);
      rdc(i_flg, 16'h0000);
      bus(i_sc1f, 1'b1, 16'h0004, 1'b0);
      $display("test second level done");
      bus(`TLEM_IDX_SMASK, 1'b1, 16'h0002, 1'b0);
      bus(i_cfg, 1'b1, 16'h0002, 1'b0);
      bus(i_cfg, 1'b1, 16'hFFFF, 1'b1);
      rdc(i_cfg, 16'h3862);
      `CHK("err_irq", 1'b1, err_irq)
      // bit 0 also set: events were missed since the last status read
      rdc(`TLEM_IDX_STAT, 16'h0003);
      repeat (2) @(posedge hclk);
      `CHK("err_irq", 1'b0, err_irq)
      bus(i_cfg, 1'b1, 16'h0000, 1'b1);
      rdc(i_cfg, 16'h0002);
      bus(`TLEM_IDX_SWCTRL, 1'b1, 16'h0001, 1'b1);
      rdc(i_flg, 16'h0002);
      `CHK("cpu_irq", 1'b1, cpu_irq)
      bus(i_flg, 1'b1, 16'h0002, 1'b1);
      rdc(i_flg, 16'h0002);
      bus(i_flg, 1'b1, 16'h0002, 1'b0);
      rdc(i_flg, 16'h0000);
      bus(16'h0100, 1'b1, 16'hFFFF, 1'b0);
      rdc(16'h0100, 16'h0000);
      $display("test application mode done");
      bus(`TLEM_IDX_STAT, 1'b0, 16'h0000, 1'b0);
      bus(`TLEM_IDX_SMASK, 1'b1, 16'h0000, 1'b0);
      bus(i_cfg, 1'b1, 16'h0800, 1'b0);
      bus(`TLEM_IDX_GATE, 1'b1, 16'h0000, 1'b0);
      pulse(0, 16'h0800);
      repeat (3) @(posedge hclk);
      `CHK("cpu_irq", 1'b0, cpu_irq)
      `CHK("err_irq", 1'b0, err_irq)
      bus(`TLEM_IDX_GATE, 1'b1, 16'h0001, 1'b0);
      repeat (2) @(posedge hclk);
      `CHK("cpu_irq", 1'b1, cpu_irq)
      $display("test global gate done");
      finish_test;
   end
endmodule // testbench

bind tlem_event_manager tlem_monitor mon
(
   .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
   .top_evt, .tmr_evt, .gpio_evt, .sc1_evt, .sc2_evt, .cpu_irq, .cpu_wake, .err_irq
);
